/* include/overload_pkg.sv */
// Package: constants and types for the overload duration integrator
package overload_pkg;
   // Accumulator width, ceiling and reset value
   localparam int ACC_WIDTH = 16;
   localparam logic [15:0] ACC_MAX = 16'hffff;
   localparam logic [15:0] ACC_RESET = 16'h0000;
   // One time unit, in microseconds, and its length in clock cycles
   localparam int TICK_US = 1000;
   localparam int CLK_MHZ = 200;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam logic [15:0] LIMIT_DEFAULT = 16'h03e8;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_DECAY = 2'b11,
      ST_ALARM = 2'b10
   } phase_t;
endpackage

/* include/tick_if.sv */
// Interface: time-unit tick between divider and integrator
`timescale 1ns/1ps
interface tick_if;
   logic tick;
   modport source (output tick);
   modport sink (input tick);
endinterface

/* logic/overload_duration_integrator.sv */
// Overload duration integrator: up/down timer with indication and alarm
`timescale 1ns/1ps
// How it works
// - Overload drives indication on and counts accumulator up each time unit.
// - Alarm rises once accumulator reaches configured limit.
// - Overload ending before alarm drops the indication output.
// - Outside overload the accumulator counts down, never cleared.
// - Overload returning resumes counting from residual value, tripping sooner.
// - Any alarm: high alarm on, low alarm off, motor stopped.
module overload_duration_integrator
   import overload_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES,
   parameter logic [15:0] ALARM_LIMIT = LIMIT_DEFAULT
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic overloadIn,
   input wire logic otherAlarmIn,
   input wire logic alarmResetIn,
   output logic overloadIndicationOut,
   output logic alarmOutActiveHigh,
   output logic alarmOutActiveLow_n,
   output logic motorStop,
   output logic [15:0] accValue
);
   // ==========================================
   // Input synchronisers
   logic [2:0] ovlSync;
   logic [2:0] othSync;
   logic [2:0] rstSync;
   logic ovl;
   logic oth;
   logic rstLvl;
   logic rstPrev;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ovlSync <= 3'h0;
         othSync <= 3'h0;
         rstSync <= 3'h0;
      end else begin
         ovlSync <= {ovlSync[1:0], overloadIn};
         othSync <= {othSync[1:0], otherAlarmIn};
         rstSync <= {rstSync[1:0], alarmResetIn};
      end
   end

   // Level changes only when stages two and three agree
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ovl <= 1'b0;
         oth <= 1'b0;
         rstLvl <= 1'b0;
         rstPrev <= 1'b0;
      end else begin
         if (ovlSync[1] == ovlSync[2]) ovl <= ovlSync[2];
         if (othSync[1] == othSync[2]) oth <= othSync[2];
         if (rstSync[1] == rstSync[2]) rstLvl <= rstSync[2];
         rstPrev <= rstLvl;
      end
   end

   wire logic resetEdge = rstLvl & ~rstPrev;

   // ==========================================
   // Time base
   tick_if tk ();
   tick_divider #(.TICK_LEN(TICK_LEN)) u_div (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tk(tk)
   );

   // ==========================================
   // Accumulator
   logic [15:0] acc;
   logic [15:0] next_acc;
   phase_t phase;
   logic alarmLatched;

   always_comb begin
      next_acc = acc;
      if (tk.tick) begin
         if (ovl) begin
            if (acc != ACC_MAX) next_acc = acc + 16'h0001;
         end else if (acc != ACC_RESET) begin
            next_acc = acc - 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) acc <= ACC_RESET;
      else acc <= next_acc;
   end

   // ==========================================
   // Phase tracking
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phase <= ST_IDLE;
      end else begin
         case (phase)
            ST_IDLE: begin
               if (ovl) phase <= ST_LOAD;
            end
            ST_LOAD: begin
               if (acc >= ALARM_LIMIT) phase <= ST_ALARM;
               else if (!ovl) phase <= ST_DECAY;
            end
            ST_DECAY: begin
               if (ovl) phase <= ST_LOAD;
               else if (acc == ACC_RESET) phase <= ST_IDLE;
            end
            ST_ALARM: begin
               if (!alarmLatched) phase <= ovl ? ST_LOAD : ST_DECAY;
            end
            default: phase <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Alarm latch; a new cause wins over a reset edge
   wire logic alarmCause = (acc >= ALARM_LIMIT) | oth;

   always_ff @(posedge core_clk) begin
      if (sys_rst) alarmLatched <= 1'b0;
      else if (alarmCause) alarmLatched <= 1'b1;
      else if (resetEdge) alarmLatched <= 1'b0;
   end

   // ==========================================
   // Outputs, all registered
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         overloadIndicationOut <= 1'b0;
         alarmOutActiveHigh <= 1'b0;
         alarmOutActiveLow_n <= 1'b1;
         motorStop <= 1'b0;
         accValue <= ACC_RESET;
      end else begin
         overloadIndicationOut <= ovl;
         alarmOutActiveHigh <= alarmLatched;
         alarmOutActiveLow_n <= ~alarmLatched;
         motorStop <= alarmLatched;
         accValue <= acc;
      end
   end

   // ==========================================
   // Checks
   // Ticks run free from reset, so the first rise may land a time unit late
   chk_acc_rises: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      (tk.tick && ovl && acc != ACC_MAX) |=> acc == $past(acc) + 16'h0001)
      else $error("accumulator did not rise in overload");

   chk_acc_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
      !tk.tick |=> $stable(acc))
      else $error("accumulator moved without tick");

   chk_ind_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      ovl |=> overloadIndicationOut)
      else $error("indication not set in overload");

   chk_alarm_trip: assert property (@(posedge core_clk) disable iff (sys_rst)
      (acc >= ALARM_LIMIT) |=> ##1 alarmOutActiveHigh)
      else $error("alarm not raised at limit");

   // An alarm that rises without a cause would trip the motor too early
   chk_alarm_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(alarmLatched) |-> $past(alarmCause))
      else $error("alarm latched without a cause");

   // Set wins: a reset edge never clears while a cause still stands
   chk_alarm_held: assert property (@(posedge core_clk) disable iff (sys_rst)
      (alarmLatched && alarmCause) |=> alarmLatched)
      else $error("alarm cleared while its cause stood");

   chk_ind_drops: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ovl |=> !overloadIndicationOut)
      else $error("indication not dropped");

   chk_acc_decays: assert property (@(posedge core_clk) disable iff (sys_rst)
      (tk.tick && !ovl && acc != ACC_RESET) |=> acc == $past(acc) - 16'h0001)
      else $error("accumulator did not decay");

   // Leaving overload must never wipe the residual count in one step
   chk_no_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      (acc > 16'h0001) |=> acc != ACC_RESET)
      else $error("accumulator cleared instead of decaying");

   chk_alarm_pins: assert property (@(posedge core_clk) disable iff (sys_rst)
      alarmOutActiveHigh == !alarmOutActiveLow_n && motorStop == alarmOutActiveHigh)
      else $error("alarm outputs disagree");

   chk_other_trip: assert property (@(posedge core_clk) disable iff (sys_rst)
      oth |=> ##1 alarmOutActiveHigh)
      else $error("other alarm cause not shown");

   chk_acc_floor: assert property (@(posedge core_clk) disable iff (sys_rst)
      (tk.tick && !ovl && acc == ACC_RESET) |=> acc == ACC_RESET)
      else $error("accumulator wrapped below zero");

   // Reaching the top takes 65535 time units; only long runs get there
   chk_acc_ceiling: assert property (@(posedge core_clk) disable iff (sys_rst)
      (acc == ACC_MAX && ovl) |=> acc == ACC_MAX)
      else $error("accumulator wrapped above max");

   // ==========================================
   // Coverage of the main scenarios
   cov_trip: cover property (@(posedge core_clk) disable iff (sys_rst)
      $rose(alarmOutActiveHigh));
   cov_resume: cover property (@(posedge core_clk) disable iff (sys_rst)
      phase == ST_DECAY ##1 phase == ST_LOAD);
   cov_decay_empty: cover property (@(posedge core_clk) disable iff (sys_rst)
      phase == ST_DECAY ##1 phase == ST_IDLE);
   cov_refused_reset: cover property (@(posedge core_clk) disable iff (sys_rst)
      resetEdge && alarmCause);
   cov_other_cause: cover property (@(posedge core_clk) disable iff (sys_rst)
      $rose(oth));
endmodule

/* logic/tick_divider.sv */
// Divider that produces one tick pulse per time unit
`timescale 1ns/1ps
module tick_divider
   import overload_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   tick_if.source tk
);
   logic [31:0] count;
   logic tickReg;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count <= 32'h00000000;
         tickReg <= 1'b0;
      end else if (count == 32'(TICK_LEN - 1)) begin
         count <= 32'h00000000;
         tickReg <= 1'b1;
      end else begin
         count <= count + 32'h00000001;
         tickReg <= 1'b0;
      end
   end

   assign tk.tick = tickReg;
endmodule

/* verif/host_observer.sv */
// Host-side observer of the alarm outputs
`timescale 1ns/1ps
module host_observer (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic alarmHigh,
   input wire logic alarmLow_n,
   input wire logic stopReq,
   output int badCount
);
   // Host only trusts the alarm while all three lines agree
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         badCount <= 0;
      end else if (alarmHigh !== ~alarmLow_n || stopReq !== alarmHigh) begin
         badCount <= badCount + 1;
      end
   end
endmodule

/* verif/tb.sv */
// Self-checking bench for the overload duration integrator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb;
   import overload_pkg::*;
   logic core_clk = 0;
   logic sys_rst = 1;
   logic overloadIn = 0;
   logic otherAlarmIn = 0;
   logic alarmResetIn = 0;
   logic ind, almHi, almLo_n, motorStop;
   logic [15:0] accValue;
   int err_count = 0;
   int n_checks = 0;
   int badCount;
   bit seenZero;
   always #2.5 core_clk = ~core_clk;
   overload_duration_integrator #(.TICK_LEN(4), .ALARM_LIMIT(16'h0005)) dut_u (
      .core_clk(core_clk), .sys_rst(sys_rst), .overloadIn(overloadIn),
      .otherAlarmIn(otherAlarmIn), .alarmResetIn(alarmResetIn), .overloadIndicationOut(ind),
      .alarmOutActiveHigh(almHi), .alarmOutActiveLow_n(almLo_n), .motorStop(motorStop),
      .accValue(accValue));
   host_observer host_u (.core_clk(core_clk), .sys_rst(sys_rst), .alarmHigh(almHi),
      .alarmLow_n(almLo_n), .stopReq(motorStop), .badCount(badCount));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic step(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   function automatic logic [15:0] seen(int sel);
      if (sel == 0) return {15'h0, ind};
      if (sel == 1) return {15'h0, almHi};
      return accValue;
   endfunction
   // Bounded wait; remembers whether the count touched zero meanwhile
   task automatic wait_on(int sel, logic [15:0] v, int bound);
      for (int i = 0; i < bound && seen(sel) !== v; i++) begin
         step(1);
         if (accValue === 16'h0000) seenZero = 1;
      end
      if (seen(sel) !== v) begin
         err_count++;
         $display("[ERR] wait sel %0d exp %0h got %0h", sel, v, seen(sel));
         tally_and_finish();
      end
   endtask
   // Reset input needs a clean synchronised edge
   task automatic pulse_reset();
      alarmResetIn = 1;
      step(6);
      alarmResetIn = 0;
      step(6);
   endtask
   task automatic partial_overload();
      `CHK("acc0", 16'h0000, accValue)
      `CHK("almLo", 1'b1, almLo_n)
      overloadIn = 1;
      wait_on(0, 1, 10);
      wait_on(2, 3, 30);
      overloadIn = 0;
      wait_on(0, 0, 10);
      `CHK("kept", 1'b1, accValue > 0)
      `CHK("almHi", 1'b0, almHi)
      wait_on(2, 2, 30);
   endtask
   task automatic early_trip();
      seenZero = 0;
      overloadIn = 1;
      wait_on(1, 1, 30);
      `CHK("noZero", 1'b0, seenZero)
      `CHK("atLim", 1'b1, accValue >= 16'h0005)
      `CHK("almLo", 1'b0, almLo_n)
      `CHK("stop", 1'b1, motorStop)
   endtask
   task automatic alarm_release();
      pulse_reset();
      `CHK("held", 1'b1, almHi)
      overloadIn = 0;
      wait_on(2, 3, 200);
      pulse_reset();
      `CHK("clr", 1'b1, almLo_n)
      wait_on(2, 0, 40);
      step(16);
      `CHK("floor", 16'h0000, accValue)
   endtask
   task automatic other_alarm();
      otherAlarmIn = 1;
      wait_on(1, 1, 10);
      `CHK("stop", 1'b1, motorStop)
      pulse_reset();
      `CHK("cause", 1'b1, almHi)
      otherAlarmIn = 0;
      step(6);
      pulse_reset();
      `CHK("clr", 1'b0, almHi)
   endtask
   // Reset in mid-run with an alarm latched and the count above zero
   task automatic midrun_reset();
      overloadIn = 1;
      otherAlarmIn = 1;
      wait_on(1, 1, 20);
      wait_on(2, 2, 40);
      `CHK("host", 0, badCount)
      sys_rst = 1;
      step(2);
      overloadIn = 0;
      otherAlarmIn = 0;
      `CHK("rstInd", 1'b0, ind)
      `CHK("rstHi", 1'b0, almHi)
      `CHK("rstLo", 1'b1, almLo_n)
      `CHK("rstStop", 1'b0, motorStop)
      `CHK("rstAcc", 16'h0000, accValue)
      sys_rst = 0;
      step(20);
      `CHK("quiet", 1'b0, almHi)
      `CHK("idle", 16'h0000, accValue)
   endtask
   initial begin
      step(8);
      sys_rst = 0;
      step(2);
      partial_overload();
      early_trip();
      alarm_release();
      other_alarm();
      midrun_reset();
      `CHK("host", 0, badCount)
      tally_and_finish();
   end
endmodule
